// ---- rtl/usfbc_defs.vh ----
`ifndef USFBC_DEFS_VH
`define USFBC_DEFS_VH

// Register byte offsets
`define USFBC_OFS_MPROC_CTRL 8'h06
`define USFBC_OFS_FRAME_CTRL 8'h07
`define USFBC_OFS_BAUD_LOW 8'h08
`define USFBC_BAUD_HIGH_STEP 8'h01
`define USFBC_OFS_AUTOBAUD 8'h0A
`define USFBC_OFS_DEBUG 8'h0B
`define USFBC_OFS_IR_EVENT 8'h0C
`define USFBC_OFS_IR_TX_PULSE 8'h0D

// Field positions
`define USFBC_MPROC_BIT 0
`define USFBC_MODE_HI 7
`define USFBC_MODE_LO 6
`define USFBC_PAR_HI 5
`define USFBC_PAR_LO 4
`define USFBC_STOP_BIT 3
`define USFBC_SIZE_HI 2
`define USFBC_SIZE_LO 0
`define USFBC_SPI_ORDER_BIT 2
`define USFBC_SPI_PHASE_BIT 1
`define USFBC_WINDOW_HI 7
`define USFBC_WINDOW_LO 6
`define USFBC_DBG_RUN_BIT 0
`define USFBC_IR_EVT_BIT 0

// Reset values
`define USFBC_RST_MODE 2'h0
`define USFBC_RST_PAR 2'h0
`define USFBC_RST_STOP 1'h0
`define USFBC_RST_SIZE 3'h3
`define USFBC_RST_SPI_BITS 1'h0
`define USFBC_RST_BAUD 16'h0000
`define USFBC_RST_BYTE 8'h00

// Communication modes
`define USFBC_MODE_ASYNC 2'h0
`define USFBC_MODE_SYNC 2'h1
`define USFBC_MODE_IR 2'h2
`define USFBC_MODE_SPI 2'h3

// Parity codes
`define USFBC_PAR_OFF 2'h0
`define USFBC_PAR_EVEN 2'h2
`define USFBC_PAR_ODD 2'h3

// Character size codes
`define USFBC_SIZE_5 3'h0
`define USFBC_SIZE_6 3'h1
`define USFBC_SIZE_7 3'h2
`define USFBC_SIZE_8 3'h3
`define USFBC_SIZE_9L 3'h6
`define USFBC_SIZE_9H 3'h7

// Auto-baud window
`define USFBC_AB_NOMINAL 8'h20
`define USFBC_AB_TOL_W0 8'h06
`define USFBC_AB_TOL_W1 8'h05
`define USFBC_AB_TOL_W2 8'h07
`define USFBC_AB_TOL_W3 8'h08

// Sampling and infrared pulse timing
`define USFBC_SAMPLES_PER_BIT 5'h10
`define USFBC_IR_316_SAMPLES 8'h03
`define USFBC_PULSE_316 8'h00
`define USFBC_PULSE_PASS 8'hFF

`endif

// ---- rtl/usfbc_core.v ----
// Notes on behaviour
// - Multiprocessor bit enables multiprocessor mode
// - Mode field selects async, sync, infrared, SPI
// - Mode 3 swaps frame register to SPI layout
// - Parity off, even, odd; code 1 reserved
// - Stop select: one or two, transmitter only
// - Size 5..8 bits, 9 low-first, 9 high-first
// - Normal frame layout resets to 0x03
// - SPI bit order: MSB first or LSB first
// - SPI phase: sample leading or trailing edge
// - Sixteen-bit divisor, low at 0x08, high next
// - Divisor write reloads prescaler at once
// - Window code sets tolerance around 32 samples
// - Sixteen samples per bit, 32 per pair
// - Debug run bit: halt or keep running
// - Infrared event enable is active low bit
// - Pulse length: 3/16, fixed clocks, or bypass
//
// The strobed register port was chosen for this implementation.
`include "usfbc_defs.vh"
`default_nettype none

module usfbc_core (
	input wire clk, // 250 MHz peripheral clock
	input wire sys_rst, // Synchronous reset, active high
	input wire [7:0] reg_addr, // Register byte address
	input wire [7:0] reg_wdata, // Register write data
	input wire reg_wr, // Write strobe
	input wire reg_rd, // Read strobe
	output reg [7:0] reg_rdata, // Read data, cycle after strobe
	input wire debug_halt, // Processor stopped in break debug
	input wire ir_event_in, // Infrared event input
	input wire tx_serial, // Transmit line level from shifter
	input wire [7:0] ab_measured, // Auto-baud samples between bits
	input wire ab_measured_valid, // Measurement strobe
	output wire multiprocessor_mode_enable, // Multiprocessor mode on
	output wire async_mode, // Asynchronous mode selected
	output wire sync_mode, // Synchronous mode selected
	output wire infrared_mode, // Infrared mode selected
	output wire spi_host_mode, // Host SPI mode selected
	output wire parity_enable, // Parity generated and checked
	output wire parity_odd, // Odd parity when enabled
	output wire tx_two_stop_bits, // Transmitter adds two stop bits
	output wire [3:0] data_bits, // Data bits per character
	output wire nine_bit_low_first, // Nine-bit, low byte first
	output wire nine_bit_high_first, // Nine-bit, high byte first
	output wire spi_lsb_first, // SPI least significant first
	output wire spi_sample_trailing, // SPI samples trailing edge
	output wire [15:0] baud_value, // Current baud divisor
	output reg baud_tick, // One pulse per baud sample
	output reg bit_tick, // One pulse per 16 samples
	output wire port_halted, // Port frozen for debug
	output reg ab_window_ok, // Last measurement in window
	output reg ab_result_valid, // Pulse with ab_window_ok
	output reg ir_event_out, // Gated infrared event
	output reg ir_tx_out // Encoded infrared transmit line
);

////////////////////////////////////////////////////////////////////////
// Register storage

reg mproc_en;
reg [1:0] comm_mode_select;
reg [1:0] parity_select;
reg stop_bit_select;
reg [2:0] char_size_select;
reg spi_bit_order;
reg spi_clock_phase;
reg [15:0] baud_divisor;
reg [1:0] autobaud_window_size;
reg run_while_halted;
reg ir_event_disable_bit;
reg [7:0] infrared_tx_pulse_length;

wire wr_mproc = reg_wr && (reg_addr == `USFBC_OFS_MPROC_CTRL);
wire wr_frame = reg_wr && (reg_addr == `USFBC_OFS_FRAME_CTRL);
wire wr_baud_lo = reg_wr && (reg_addr == `USFBC_OFS_BAUD_LOW);
wire wr_baud_hi = reg_wr &&
	(reg_addr == (`USFBC_OFS_BAUD_LOW + `USFBC_BAUD_HIGH_STEP));
wire wr_ab = reg_wr && (reg_addr == `USFBC_OFS_AUTOBAUD);
wire wr_dbg = reg_wr && (reg_addr == `USFBC_OFS_DEBUG);
wire wr_evt = reg_wr && (reg_addr == `USFBC_OFS_IR_EVENT);
wire wr_infrared_tx_pulse_length = reg_wr && (reg_addr == `USFBC_OFS_IR_TX_PULSE);
wire new_mode_spi = (reg_wdata[`USFBC_MODE_HI:`USFBC_MODE_LO] ==
	`USFBC_MODE_SPI);

// Both frame layouts live behind one address; the written mode picks
// which fields a write lands in, so the other layout keeps its values
always @(posedge clk) begin
	if (sys_rst) begin
		mproc_en <= 1'b0;
		comm_mode_select <= `USFBC_RST_MODE;
		parity_select <= `USFBC_RST_PAR;
		stop_bit_select <= `USFBC_RST_STOP;
		char_size_select <= `USFBC_RST_SIZE;
		spi_bit_order <= `USFBC_RST_SPI_BITS;
		spi_clock_phase <= `USFBC_RST_SPI_BITS;
		baud_divisor <= `USFBC_RST_BAUD;
		autobaud_window_size <= 2'h0;
		run_while_halted <= 1'b0;
		ir_event_disable_bit <= 1'b0;
		infrared_tx_pulse_length <= `USFBC_RST_BYTE;
	end else begin
		if (wr_mproc) begin
			mproc_en <= reg_wdata[`USFBC_MPROC_BIT];
		end
		if (wr_frame) begin
			comm_mode_select <=
				reg_wdata[`USFBC_MODE_HI:`USFBC_MODE_LO];
			if (new_mode_spi) begin
				spi_bit_order <=
					reg_wdata[`USFBC_SPI_ORDER_BIT];
				spi_clock_phase <=
					reg_wdata[`USFBC_SPI_PHASE_BIT];
			end else begin
				parity_select <=
					reg_wdata[`USFBC_PAR_HI:`USFBC_PAR_LO];
				stop_bit_select <= reg_wdata[`USFBC_STOP_BIT];
				char_size_select <=
					reg_wdata[`USFBC_SIZE_HI:`USFBC_SIZE_LO];
			end
		end
		if (wr_baud_lo) begin
			baud_divisor[7:0] <= reg_wdata;
		end
		if (wr_baud_hi) begin
			baud_divisor[15:8] <= reg_wdata;
		end
		if (wr_ab) begin
			autobaud_window_size <=
				reg_wdata[`USFBC_WINDOW_HI:`USFBC_WINDOW_LO];
		end
		if (wr_dbg) begin
			run_while_halted <= reg_wdata[`USFBC_DBG_RUN_BIT];
		end
		if (wr_evt) begin
			ir_event_disable_bit <= reg_wdata[`USFBC_IR_EVT_BIT];
		end
		if (wr_infrared_tx_pulse_length) begin
			infrared_tx_pulse_length <= reg_wdata;
		end
	end
end

////////////////////////////////////////////////////////////////////////
// Read port

reg [7:0] next_rdata;

// Frame register shows only the fields of the layout now in force
always @* begin
	next_rdata = 8'h00;
	if (reg_addr == `USFBC_OFS_MPROC_CTRL) begin
		next_rdata[`USFBC_MPROC_BIT] = mproc_en;
	end else if (reg_addr == `USFBC_OFS_FRAME_CTRL) begin
		next_rdata[`USFBC_MODE_HI:`USFBC_MODE_LO] = comm_mode_select;
		if (spi_host_mode) begin
			next_rdata[`USFBC_SPI_ORDER_BIT] = spi_bit_order;
			next_rdata[`USFBC_SPI_PHASE_BIT] = spi_clock_phase;
		end else begin
			next_rdata[`USFBC_PAR_HI:`USFBC_PAR_LO] = parity_select;
			next_rdata[`USFBC_STOP_BIT] = stop_bit_select;
			next_rdata[`USFBC_SIZE_HI:`USFBC_SIZE_LO] = char_size_select;
		end
	end else if (reg_addr == `USFBC_OFS_BAUD_LOW) begin
		next_rdata = baud_divisor[7:0];
	end else if (reg_addr ==
		(`USFBC_OFS_BAUD_LOW + `USFBC_BAUD_HIGH_STEP)) begin
		next_rdata = baud_divisor[15:8];
	end else if (reg_addr == `USFBC_OFS_AUTOBAUD) begin
		next_rdata[`USFBC_WINDOW_HI:`USFBC_WINDOW_LO] =
			autobaud_window_size;
	end else if (reg_addr == `USFBC_OFS_DEBUG) begin
		next_rdata[`USFBC_DBG_RUN_BIT] = run_while_halted;
	end else if (reg_addr == `USFBC_OFS_IR_EVENT) begin
		next_rdata[`USFBC_IR_EVT_BIT] = ir_event_disable_bit;
	end else if (reg_addr == `USFBC_OFS_IR_TX_PULSE) begin
		next_rdata = infrared_tx_pulse_length;
	end
end

// Data is valid only in the cycle after the read strobe, zero otherwise
always @(posedge clk) begin
	if (sys_rst) begin
		reg_rdata <= 8'h00;
	end else if (reg_rd) begin
		reg_rdata <= next_rdata;
	end else begin
		reg_rdata <= 8'h00;
	end
end

////////////////////////////////////////////////////////////////////////
// Decoded configuration

assign multiprocessor_mode_enable = mproc_en;
assign async_mode = (comm_mode_select == `USFBC_MODE_ASYNC);
assign sync_mode = (comm_mode_select == `USFBC_MODE_SYNC);
assign infrared_mode = (comm_mode_select == `USFBC_MODE_IR);
assign spi_host_mode = (comm_mode_select == `USFBC_MODE_SPI);
// Reserved parity code 1 is treated as parity off
assign parity_enable = !spi_host_mode &&
	((parity_select == `USFBC_PAR_EVEN) ||
	(parity_select == `USFBC_PAR_ODD));
assign parity_odd = parity_enable &&
	(parity_select == `USFBC_PAR_ODD);
// Receiver never looks at this; it feeds the transmitter only
assign tx_two_stop_bits = !spi_host_mode && stop_bit_select;
assign nine_bit_low_first = (char_size_select == `USFBC_SIZE_9L);
assign nine_bit_high_first = (char_size_select == `USFBC_SIZE_9H);
assign spi_lsb_first = spi_host_mode && spi_bit_order;
assign spi_sample_trailing = spi_host_mode && spi_clock_phase;
assign baud_value = baud_divisor;

reg [3:0] size_bits;

// Reserved size codes fall back to eight bits
always @* begin
	case (char_size_select)
		`USFBC_SIZE_5: size_bits = 4'h5;
		`USFBC_SIZE_6: size_bits = 4'h6;
		`USFBC_SIZE_7: size_bits = 4'h7;
		`USFBC_SIZE_9L: size_bits = 4'h9;
		`USFBC_SIZE_9H: size_bits = 4'h9;
		default: size_bits = 4'h8;
	endcase
end
assign data_bits = size_bits;

////////////////////////////////////////////////////////////////////////
// Debug halt

assign port_halted = debug_halt && !run_while_halted;

////////////////////////////////////////////////////////////////////////
// Baud prescaler and bit timing

reg [15:0] presc_cnt;
reg [4:0] sample_cnt;

// A divisor write restarts timing at once, mid-frame if need be
always @(posedge clk) begin
	if (sys_rst) begin
		presc_cnt <= `USFBC_RST_BAUD;
		sample_cnt <= 5'h00;
		baud_tick <= 1'b0;
		bit_tick <= 1'b0;
	end else if (wr_baud_lo || wr_baud_hi) begin
		presc_cnt <= wr_baud_lo ? {baud_divisor[15:8], reg_wdata} :
			{reg_wdata, baud_divisor[7:0]};
		sample_cnt <= 5'h00;
		baud_tick <= 1'b0;
		bit_tick <= 1'b0;
	end else if (port_halted) begin
		baud_tick <= 1'b0;
		bit_tick <= 1'b0;
	end else if (presc_cnt == 16'h0000) begin
		presc_cnt <= baud_divisor;
		baud_tick <= 1'b1;
		if (sample_cnt == (`USFBC_SAMPLES_PER_BIT - 5'h01)) begin
			sample_cnt <= 5'h00;
			bit_tick <= 1'b1;
		end else begin
			sample_cnt <= sample_cnt + 5'h01;
			bit_tick <= 1'b0;
		end
	end else begin
		presc_cnt <= presc_cnt - 16'h0001;
		baud_tick <= 1'b0;
		bit_tick <= 1'b0;
	end
end

////////////////////////////////////////////////////////////////////////
// Auto-baud window check

reg [7:0] ab_tol;

always @* begin
	case (autobaud_window_size)
		2'h0: ab_tol = `USFBC_AB_TOL_W0;
		2'h1: ab_tol = `USFBC_AB_TOL_W1;
		2'h2: ab_tol = `USFBC_AB_TOL_W2;
		default: ab_tol = `USFBC_AB_TOL_W3;
	endcase
end

// Matched rates give 32 samples per bit pair; accept within tolerance
always @(posedge clk) begin
	if (sys_rst) begin
		ab_window_ok <= 1'b0;
		ab_result_valid <= 1'b0;
	end else begin
		ab_result_valid <= ab_measured_valid && !port_halted;
		if (ab_measured_valid && !port_halted) begin
			ab_window_ok <=
				(ab_measured >= (`USFBC_AB_NOMINAL - ab_tol)) &&
				(ab_measured <= (`USFBC_AB_NOMINAL + ab_tol));
		end
	end
end

////////////////////////////////////////////////////////////////////////
// Infrared event input

// Stored bit is a disable: zero lets events through
always @(posedge clk) begin
	if (sys_rst) begin
		ir_event_out <= 1'b0;
	end else begin
		ir_event_out <= ir_event_in && !ir_event_disable_bit &&
			!port_halted;
	end
end

////////////////////////////////////////////////////////////////////////
// Infrared transmit pulse encoder

localparam IR_IDLE = 2'b01;
localparam IR_PULSE = 2'b10;

reg [1:0] ir_state;
reg [7:0] pulse_cnt;
reg pulse_by_samples;
wire ir_bypass = (infrared_tx_pulse_length == `USFBC_PULSE_PASS);
wire ir_316 = (infrared_tx_pulse_length == `USFBC_PULSE_316);

// A zero bit is sent as one short high pulse at the bit start; the
// pulse length is latched so a late register write cannot stretch it
always @(posedge clk) begin
	if (sys_rst) begin
		ir_state <= IR_IDLE;
		pulse_cnt <= 8'h00;
		pulse_by_samples <= 1'b0;
		ir_tx_out <= 1'b0;
	end else if (!infrared_mode || ir_bypass) begin
		ir_state <= IR_IDLE;
		pulse_cnt <= 8'h00;
		ir_tx_out <= tx_serial;
	end else begin
		case (ir_state)
			IR_IDLE: begin
				ir_tx_out <= 1'b0;
				if (bit_tick && !tx_serial) begin
					ir_state <= IR_PULSE;
					ir_tx_out <= 1'b1;
					pulse_by_samples <= ir_316;
					pulse_cnt <= ir_316 ? `USFBC_IR_316_SAMPLES :
						infrared_tx_pulse_length;
				end
			end
			IR_PULSE: begin
				if (pulse_by_samples && !baud_tick) begin
					ir_tx_out <= 1'b1;
				end else if (pulse_cnt == 8'h01) begin
					ir_state <= IR_IDLE;
					ir_tx_out <= 1'b0;
					pulse_cnt <= 8'h00;
				end else begin
					pulse_cnt <= pulse_cnt - 8'h01;
					ir_tx_out <= 1'b1;
				end
			end
			default: begin
				ir_state <= IR_IDLE;
				ir_tx_out <= 1'b0;
			end
		endcase
	end
end

endmodule

`default_nettype wire

// ---- dv/usfbc_core_props.sv ----
`default_nettype none
module usfbc_core_props (
	input wire logic clk, sys_rst, reg_wr, reg_rd, // Clock, reset, strobes
	input wire logic [7:0] reg_addr, reg_wdata, reg_rdata, // Register bus
	input wire logic ir_event_in, ab_measured_valid, // Far-side inputs
	input wire logic [7:0] ab_measured, // Auto-baud count
	input wire logic async_mode, sync_mode, infrared_mode, // Mode decodes
	input wire logic spi_host_mode, parity_enable, tx_two_stop_bits, // Format
	input wire logic [3:0] data_bits, // Character size
	input wire logic nine_bit_low_first, nine_bit_high_first, // Byte order
	input wire logic spi_lsb_first, spi_sample_trailing, // SPI format
	input wire logic [15:0] baud_value, // Divisor
	input wire logic baud_tick, bit_tick, port_halted, // Timing
	input wire logic ab_window_ok, ab_result_valid, // Auto-baud result
	input wire logic ir_event_out, ir_tx_out // Infrared outputs
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);

	////////////////////////////////////////////////////////////////////////
	// Read data must not linger, or software could read stale values
	chk_rd_idle_zero: assert property (
		!$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("read data not zero when idle");
	chk_mode_onehot: assert property (
		$onehot({async_mode, sync_mode, infrared_mode, spi_host_mode}))
		else $error("mode decode not one-hot");
	chk_spi_layout: assert property (
		spi_host_mode |-> !parity_enable && !tx_two_stop_bits)
		else $error("normal fields active in SPI mode");
	chk_spi_gate: assert property (
		!spi_host_mode |-> !spi_lsb_first && !spi_sample_trailing)
		else $error("SPI bits active outside SPI mode");
	chk_nine_bits: assert property (
		nine_bit_low_first || nine_bit_high_first |-> data_bits == 4'h9)
		else $error("nine-bit size not nine bits");
	// A small divisor written must give a tick within four cycles, not after old count
	chk_baud_reload: assert property (
		reg_wr && reg_addr == 8'h08 && reg_wdata < 8'h03 &&
		baud_value[15:8] == 8'h00 && !port_halted |-> ##[1:4] baud_tick)
		else $error("divisor write did not reload prescaler");
	chk_bit_in_baud: assert property (
		bit_tick |-> baud_tick)
		else $error("bit tick without sample tick");
	chk_halt_freeze: assert property (
		port_halted && $past(port_halted) |-> !baud_tick && !bit_tick)
		else $error("ticks while halted");
	chk_ab_answer: assert property (
		ab_measured_valid && !port_halted |=> ab_result_valid)
		else $error("auto-baud result missing");
	chk_ab_exact: assert property (
		ab_measured_valid && !port_halted && ab_measured == 8'h20
		|=> ab_window_ok)
		else $error("matched rate rejected");
	chk_ir_event: assert property (
		ir_event_out |-> $past(ir_event_in) && !$past(port_halted))
		else $error("event passed without cause");

	cover property (spi_host_mode && spi_lsb_first);
	cover property (ab_result_valid && !ab_window_ok);
	cover property (infrared_mode && ir_tx_out);
	cover property (port_halted);
endmodule
`default_nettype wire

// ---- dv/usfbc_peer.sv ----
`default_nettype none
module usfbc_peer (
	input wire logic clk, // Shared clock
	input wire logic meas_go, // Send one measurement
	input wire logic [7:0] meas_cnt, // Samples counted between two bits
	output var logic [7:0] ab_measured = 8'hA5, // Count to the port
	output var logic ab_measured_valid = 1'b0 // One-cycle qualifier
);
	timeunit 1ns;
	timeprecision 1ps;
	// Count scrambles outside its qualifier so no stale value passes
	always @(posedge clk) begin
		ab_measured_valid <= meas_go;
		ab_measured <= meas_go ? meas_cnt : ~ab_measured;
	end
endmodule
`default_nettype wire

// ---- dv/usfbc_core_bench.sv ----
`default_nettype none
module usfbc_core_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
	logic debug_halt = 1'b0, ir_event_in = 1'b0, tx_serial = 1'b1;
	logic meas_go = 1'b0;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, meas_cnt = 8'h00;
	wire [7:0] reg_rdata, ab_measured;
	wire [3:0] data_bits;
	wire [15:0] baud_value;
	wire ab_measured_valid, multiprocessor_mode_enable, async_mode;
	wire sync_mode, infrared_mode, spi_host_mode, parity_enable, parity_odd;
	wire tx_two_stop_bits, nine_bit_low_first, nine_bit_high_first;
	wire spi_lsb_first, spi_sample_trailing, baud_tick, bit_tick;
	wire port_halted, ab_window_ok, ab_result_valid, ir_event_out, ir_tx_out;
	int err_count = 0;
	int samples_checked = 0;

	usfbc_core u_dut (.clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr,
		.reg_rd, .reg_rdata, .debug_halt, .ir_event_in, .tx_serial,
		.ab_measured, .ab_measured_valid, .multiprocessor_mode_enable,
		.async_mode, .sync_mode, .infrared_mode, .spi_host_mode,
		.parity_enable, .parity_odd, .tx_two_stop_bits, .data_bits,
		.nine_bit_low_first, .nine_bit_high_first, .spi_lsb_first,
		.spi_sample_trailing, .baud_value, .baud_tick, .bit_tick,
		.port_halted, .ab_window_ok, .ab_result_valid, .ir_event_out,
		.ir_tx_out);
	usfbc_peer u_peer (.clk, .meas_go, .meas_cnt, .ab_measured,
		.ab_measured_valid);

	// 250 MHz clock
	initial begin
		forever #2 clk = ~clk;
	end

	////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_count++;
			$display("FAIL %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic conclude;
		$display("checks %0d errors %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic timeout;
		err_count++;
		$display("FAIL %0t wait ran out", $time);
		conclude;
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// Strobes last one cycle; the trailing delay lets the taken edge land
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		check(reg_rdata, exp);
	endtask
	task automatic measure(input logic [7:0] c);
		@(posedge clk);
		meas_go <= 1'b1;
		meas_cnt <= c;
		@(posedge clk);
		meas_go <= 1'b0;
		step(1);
	endtask
	// Cycles until the next sample tick, or bit tick when use_bit is set
	task automatic gap(input logic use_bit, output int n);
		n = 0;
		do begin
			step(1);
			n++;
			if (n > 300)
				timeout;
		end while ((use_bit ? bit_tick : baud_tick) !== 1'b1);
	endtask

	////////////////////////////////////////////////////////////////////////
	task automatic t_reset;
		check({async_mode, data_bits}, 5'h18);
		rd(8'h07, 8'h03);
		for (int i = 6; i < 15; i++)
			if (i != 7) rd(8'(i), 8'h00);
	endtask
	task automatic t_mproc;
		wr(8'h06, 8'hFF);
		check(multiprocessor_mode_enable, 1'b1);
		rd(8'h06, 8'h01);
		wr(8'h06, 8'h00);
		check(multiprocessor_mode_enable, 1'b0);
	endtask
	task automatic t_frame;
		logic [7:0] v;
		for (int i = 0; i < 8; i++) begin
			v = {2'(i % 3), 2'(i % 4), 1'(i / 4), 3'(i)};
			wr(8'h07, v);
			rd(8'h07, v);
			check({async_mode, sync_mode, infrared_mode}, 3'h4 >> v[7:6]);
			check(parity_enable, v[5]);
			check(parity_odd, v[5:4] == 2'h3);
			check(tx_two_stop_bits, v[3]);
			check(data_bits, v[2:0] > 3'h5 ? 4'h9 : v[2:0] > 3'h3 ? 4'h8 :
				{1'b0, v[2:0]} + 4'h5);
			check(nine_bit_low_first, v[2:0] == 3'h6);
			check(nine_bit_high_first, v[2:0] == 3'h7);
		end
	endtask
	task automatic t_spi;
		wr(8'h07, 8'hFF);
		rd(8'h07, 8'hC6);
		check({spi_host_mode, spi_lsb_first, parity_enable}, 3'h6);
		check(spi_sample_trailing, 1'b1);
		wr(8'h07, 8'hC0); // Nothing in flight while order changes
		check({spi_lsb_first, spi_sample_trailing}, 2'h0);
		wr(8'h07, 8'h44);
		rd(8'h07, 8'h44);
	endtask
	task automatic t_baud;
		int n;
		wr(8'h09, 8'h12);
		wr(8'h08, 8'h34);
		check(baud_value, 16'h1234);
		rd(8'h09, 8'h12);
		rd(8'h08, 8'h34);
		wr(8'h09, 8'h00); // Divisor changes mid-count; the prescaler reloads at once
		step(5);
		wr(8'h08, 8'h02);
		gap(1'b0, n);
		check(n <= 4, 1'b1);
		gap(1'b0, n);
		check(n, 16'd3);
		wr(8'h08, 8'h00);
		gap(1'b1, n);
		gap(1'b1, n);
		check(n, 16'd16);
	endtask
	task automatic t_ab;
		logic [7:0] tol, c;
		for (int k = 0; k < 4; k++) begin
			tol = k == 0 ? 8'h06 : k == 1 ? 8'h05 : k == 2 ? 8'h07 : 8'h08;
			wr(8'h0A, {2'(k), 6'h00});
			rd(8'h0A, {2'(k), 6'h00});
			for (int j = 0; j < 4; j++) begin
				c = j[1] ? 8'h20 - tol - 8'(j[0]) : 8'h20 + tol + 8'(j[0]);
				measure(c);
				check({ab_result_valid, ab_window_ok}, {1'b1, !j[0]});
			end
		end
	endtask
	task automatic t_debug;
		@(posedge clk);
		debug_halt <= 1'b1;
		measure(8'h20);
		check({port_halted, baud_tick, ab_result_valid}, 3'h4);
		wr(8'h0B, 8'h01);
		rd(8'h0B, 8'h01);
		check({port_halted, baud_tick}, 2'h1);
		measure(8'h20);
		check(ab_result_valid, 1'b1);
		wr(8'h0B, 8'h00);
		@(posedge clk);
		debug_halt <= 1'b0;
	endtask
	task automatic t_irevt;
		@(posedge clk);
		ir_event_in <= 1'b1;
		step(2);
		check(ir_event_out, 1'b1);
		wr(8'h0C, 8'h01);
		step(1);
		check(ir_event_out, 1'b0);
		rd(8'h0C, 8'h01);
		wr(8'h0C, 8'h00);
		@(posedge clk);
		debug_halt <= 1'b1;
		step(2);
		check(ir_event_out, 1'b0);
		@(posedge clk);
		debug_halt <= 1'b0;
		ir_event_in <= 1'b0;
	endtask
	// One zero bit from the shifter, then the high time of the pulse
	task automatic pulse(input logic [7:0] len, input int exp);
		int n;
		wr(8'h0D, len);
		@(posedge clk);
		tx_serial <= 1'b0;
		n = 0;
		while (ir_tx_out !== 1'b1) begin
			step(1);
			n++;
			if (n > 40)
				timeout;
		end
		n = 0;
		while (ir_tx_out === 1'b1 && n < 300) begin
			step(1);
			n++;
		end
		@(posedge clk);
		tx_serial <= 1'b1;
		check(n, 16'(exp));
	endtask
	task automatic t_ir_tx;
		wr(8'h07, 8'h83);
		pulse(8'h02, 2);
		pulse(8'h05, 5);
		pulse(8'h00, 3);
		wr(8'h0D, 8'hFF);
		step(2);
		check(ir_tx_out, 1'b1);
		@(posedge clk);
		tx_serial <= 1'b0;
		step(1);
		check(ir_tx_out, 1'b0);
	endtask

	////////////////////////////////////////////////////////////////////////
	// Reset for 12 cycles, then the scenarios in turn
	initial begin
		repeat (12) @(posedge clk);
		sys_rst <= 1'b0;
		#1;
		t_reset;
		t_mproc;
		t_frame;
		t_spi;
		t_baud;
		t_ab;
		t_debug;
		t_irevt;
		t_ir_tx;
		conclude;
	end
endmodule

bind usfbc_core usfbc_core_props u_props (.clk, .sys_rst, .reg_wr, .reg_rd,
	.reg_addr, .reg_wdata, .reg_rdata, .ir_event_in, .ab_measured_valid,
	.ab_measured, .async_mode, .sync_mode, .infrared_mode, .spi_host_mode,
	.parity_enable, .tx_two_stop_bits, .data_bits, .nine_bit_low_first,
	.nine_bit_high_first, .spi_lsb_first, .spi_sample_trailing, .baud_value,
	.baud_tick, .bit_tick, .port_halted, .ab_window_ok, .ab_result_valid,
	.ir_event_out, .ir_tx_out);
`default_nettype wire
